// [logic/cell_group.sv]
// one group of logic cells with shared register controls and apb config
//
// Overview of operation
// R1: normal mode lets lut and register work apart
// R2: carry input in normal mode disables packing
// R3: exactly two group clock enables, selectable
// R4: first cell has register feedback multiplexer
// R5: inputs one/two take feedback, except second cell; the code feeds back into input one only
// R6: group sync clear/load act on all registers
// R7: counter mode uses two three-input luts
// R8: load multiplexer and clearing and gate
// R9: sync clear/load override the cascade chain
// R10: sync clear wins over sync load
// R11: arithmetic mode drives registered and combinational outputs
// R12: group lines drive clear; native async clear
// R13: preset by inverting around the async clear
// R14: dual emulation costs three more cells
// R15: dual-emulated registers undefined after reset
// R16: enabled chip reset clears every register
// R17: chip reset overrides every other control
// R18: preset registers read one during chip reset
// R19: chip reset use fixed before build
// R20: four global lines from pins or logic
// R21: disabled clock enable holds the register
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "cell_group_defines.svh"

module cell_group
    import cell_group_pkg::*;
#(
    parameter int CELLS = 8,              // cells per group, at most 8
    parameter bit RESET_PIN_EN = 1'b1     // chip reset pin in use  // R19
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_register_reset_n,
    input wire logic [3:0] global_pin,
    input wire logic [CELLS-1:0][3:0] cell_data,
    input wire logic carry_in,
    input wire logic cascade_in,
    output logic [CELLS-1:0] cell_comb_out,
    output logic [CELLS-1:0] cell_reg_out,
    output logic carry_out,
    output logic cascade_out
);

    localparam int IDX_W = (CELLS > 1) ? $clog2(CELLS) : 1;

    // software-visible state
    logic [`CTRL_W-1:0] ctrl_reg;          // group control word
    logic [IDX_W-1:0] sel_reg;             // cell chosen for config access
    cell_cfg_t cfg_reg [CELLS];            // per-cell configuration
    logic [CELLS-1:0] load_reg;            // sync load data, one bit a cell
    logic [31:0] rd_data_reg;              // read data held for access phase
    logic [31:0] rd_next;

    // pin synchronisers; the first stage feeds only the second
    logic rstpin_meta_reg;
    logic rstpin_sync_reg;
    logic [3:0] gpin_meta_reg;
    logic [3:0] gpin_sync_reg;
    logic greset_reg;                      // chip reset active, registered

    // cell storage: preset cells hold the inverted value
    logic [CELLS-1:0] store_reg;
    logic [CELLS-1:0] known_reg;           // value defined since reset

    // combinational cell network
    logic [3:0] gline;                     // the four global lines
    logic g_aclr;
    logic g_apre;
    logic g_sclr;
    logic g_sload;
    logic [CELLS-1:0] d_vec;               // value offered to each register
    logic [CELLS-1:0] nxt_vec;             // after sync clear/load
    logic [CELLS-1:0] pe_vec;
    logic [CELLS-1:0] dual_vec;
    logic [CELLS-1:0] en_vec;
    logic [CELLS-1:0] aclr_vec;
    logic [CELLS-1:0] live_vec;
    logic [CELLS-1:0] upd_vec;
    logic [7:0] used_cells;
    logic wr_en;
    logic mapped;
    logic sel_ok;

    // lookup of a four-input table
    function automatic logic lut4(input logic [15:0] mask,
                                  input logic [3:0] idx);
        return mask[idx];
    endfunction : lut4

    // lookup of a three-input table
    function automatic logic lut3(input logic [7:0] mask,
                                  input logic [2:0] idx);
        return mask[idx];
    endfunction : lut3

    // ---------------- apb slave ----------------

    assign pready = 1'b1;                  // zero wait states
    assign prdata = rd_data_reg;
    assign wr_en = psel & penable & pwrite;
    assign sel_ok = int'(sel_reg) < CELLS;

    // address decode; status is read-only but still mapped
    always_comb begin
        unique case (paddr)
            `OFS_CTRL, `OFS_CELL_SEL, `OFS_CELL_CFG,
            `OFS_LOAD_DATA, `OFS_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~mapped;

    // read multiplexer, sampled in the setup cycle
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (paddr)
            `OFS_CTRL: rd_next = 32'(ctrl_reg);
            `OFS_CELL_SEL: rd_next = 32'(sel_reg);
            `OFS_CELL_CFG: begin
                if (sel_ok) begin
                    rd_next = 32'(cfg_reg[sel_reg]);
                end
            end
            `OFS_LOAD_DATA: rd_next = 32'(load_reg);
            `OFS_STATUS: begin
                rd_next = {used_cells, gline, 3'h0, greset_reg,
                           8'(known_reg), 8'(cell_reg_out)};
            end
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // read data register: status is a snapshot from the setup cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            rd_data_reg <= rd_next;
        end
    end

    // writable registers; a write to an absent cell index is dropped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RST;
            sel_reg <= '0;
            load_reg <= '0;
            for (int i = 0; i < CELLS; i++) begin
                cfg_reg[i] <= '0;
            end
        end else if (wr_en) begin
            unique case (paddr)
                `OFS_CTRL: ctrl_reg <= pwdata[`CTRL_W-1:0];
                `OFS_CELL_SEL: sel_reg <= pwdata[IDX_W-1:0];
                `OFS_CELL_CFG: begin
                    if (sel_ok) begin
                        cfg_reg[sel_reg] <= pwdata[23:0];
                    end
                end
                `OFS_LOAD_DATA: load_reg <= pwdata[CELLS-1:0];
                default: ;
            endcase
        end
    end

    // ---------------- global lines and chip reset ----------------

    // pins cross into ref_clk through two flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rstpin_meta_reg <= 1'b1;
            rstpin_sync_reg <= 1'b1;
            gpin_meta_reg <= 4'h0;
            gpin_sync_reg <= 4'h0;
        end else begin
            rstpin_meta_reg <= global_register_reset_n;
            rstpin_sync_reg <= rstpin_meta_reg;
            gpin_meta_reg <= global_pin;
            gpin_sync_reg <= gpin_meta_reg;
        end
    end

    // chip reset is honoured only if built in; not switchable by software
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            greset_reg <= 1'b0;
        end else begin
            greset_reg <= RESET_PIN_EN & ~rstpin_sync_reg; // R16 R19
        end
    end

    // each global line comes from its pin or from internal logic
    assign gline = (ctrl_reg[`CTRL_GSRC_LSB +: 4] & // R20
                    ctrl_reg[`CTRL_GINT_LSB +: 4]) |
                   (~ctrl_reg[`CTRL_GSRC_LSB +: 4] & gpin_sync_reg);

    // group-wide controls: register bit or a global line
    assign g_aclr = ctrl_reg[`CTRL_ACLR] | gline[0]; // R12
    assign g_apre = ctrl_reg[`CTRL_APRE] | gline[1];
    assign g_sclr = ctrl_reg[`CTRL_SCLR] | gline[2];
    assign g_sload = ctrl_reg[`CTRL_SLOAD] | gline[3];

    // ---------------- cell network ----------------

    // luts, carry and cascade chains, walked from cell 0 upward
    always_comb begin
        logic cin;
        logic casc;
        logic cout;
        logic comb;
        logic [3:0] li;
        cin = carry_in;
        casc = cascade_in;
        cout = 1'b0;
        comb = 1'b0;
        li = 4'h0;
        for (int i = 0; i < CELLS; i++) begin
            li = cell_data[i];
            // feedback into input one; the second cell lacks it
            if (cfg_reg[i].feedback && i != 1) begin
                li[0] = cell_reg_out[i]; // R4 R5
            end
            unique case (cfg_reg[i].mode)
                MODE_NORMAL: begin
                    if (cfg_reg[i].use_carry) begin
                        li[2] = cin;
                    end
                    comb = lut4(cfg_reg[i].lut_mask, li);
                    cout = 1'b0;
                end
                MODE_ARITH, MODE_COUNTER: begin
                    // one table for the data, one for the fast carry
                    comb = lut3(cfg_reg[i].lut_mask[7:0], // R7
                                {cin, li[1], li[0]});
                    cout = lut3(cfg_reg[i].lut_mask[15:8],
                                {cin, li[1], li[0]});
                end
                default: begin
                    comb = 1'b0;
                    cout = 1'b0;
                end
            endcase
            comb = comb & casc;
            cell_comb_out[i] = comb; // R11
            // packing: register takes input four, lut stays free
            if (cfg_reg[i].mode == MODE_NORMAL && cfg_reg[i].pack_en &&
                !cfg_reg[i].use_carry) begin
                d_vec[i] = cell_data[i][3]; // R1 R2
            end else begin
                d_vec[i] = comb;
            end
            casc = comb;
            cin = cout;
        end
        carry_out = cin;
        cascade_out = casc;
    end

    // per-cell control decode; clear and load sit after the cascade
    always_comb begin
        for (int i = 0; i < CELLS; i++) begin
            pe_vec[i] = cfg_reg[i].preset_emu;
            dual_vec[i] = cfg_reg[i].dual_emu;
            en_vec[i] = cfg_reg[i].ce_sel ? ctrl_reg[`CTRL_CE1] : // R3
                                            ctrl_reg[`CTRL_CE0];
            // preset cells see the preset line on their native clear
            aclr_vec[i] = cfg_reg[i].preset_emu ? g_apre : g_aclr; // R13
            if (g_sclr) begin
                nxt_vec[i] = 1'b0; // R8 R9 R10
            end else if (g_sload) begin
                nxt_vec[i] = load_reg[i]; // R8 R9
            end else begin
                nxt_vec[i] = d_vec[i];
            end
        end
    end

    assign live_vec = en_vec & ~aclr_vec;
    assign upd_vec = en_vec | aclr_vec | {CELLS{greset_reg}};

    // cell registers: chip reset, then async clear, then clock enable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            store_reg <= '0;
            known_reg <= '0;
        end else begin
            for (int i = 0; i < CELLS; i++) begin
                if (greset_reg) begin
                    store_reg[i] <= 1'b0; // R16 R17 R18
                    known_reg[i] <= ~dual_vec[i]; // R15
                end else if (aclr_vec[i]) begin
                    store_reg[i] <= 1'b0; // R12 R13
                    known_reg[i] <= 1'b1;
                end else if (en_vec[i]) begin
                    // group sync controls reach every enabled cell
                    store_reg[i] <= nxt_vec[i] ^ pe_vec[i]; // R6
                    known_reg[i] <= 1'b1;
                end
                // otherwise the register holds its value  // R21
            end
        end
    end

    // output inverter undoes the storage inversion of preset cells
    assign cell_reg_out = store_reg ^ pe_vec; // R13

    // cells consumed: each dual emulation needs three helpers
    always_comb begin
        used_cells = 8'(CELLS);
        for (int i = 0; i < CELLS; i++) begin
            if (dual_vec[i]) begin
                used_cells = used_cells + `EXTRA_CELLS_PER_EMU; // R14
            end
        end
    end

    // ---------------- assertions ----------------

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (rst);

    // chip reset pulse ending with no config change
    sequence reset_pulse;
        greset_reg ##1 (!greset_reg && !wr_en);
    endsequence

    // pin held low over three samples
    sequence pin_held;
        (!global_register_reset_n && RESET_PIN_EN)[*3];
    endsequence

    rst_pin_a: assert property (pin_held |=> greset_reg) // R16
        else $error("chip reset pin did not reach cell registers");

    rst_prio_a: assert property ( // R17
        (greset_reg && !wr_en) |=> ((cell_reg_out & ~pe_vec) == '0))
        else $error("chip reset did not clear plain cells");

    preset_rst_a: assert property ( // R18
        (greset_reg && !wr_en) |=> ((cell_reg_out & pe_vec) == pe_vec))
        else $error("preset cells not high under chip reset");

    dual_unknown_a: assert property ( // R15
        reset_pulse |-> ((known_reg & dual_vec) == '0))
        else $error("dual emulated cell marked known after reset");

    clr_over_load_a: assert property ( // R10
        (!greset_reg && g_sclr && g_sload && !wr_en)
        |=> ((cell_reg_out & $past(live_vec)) == '0))
        else $error("sync load won over sync clear");

    load_a: assert property ( // R6
        (!greset_reg && !g_sclr && g_sload && !wr_en)
        |=> ((cell_reg_out & $past(live_vec)) ==
             ($past(load_reg) & $past(live_vec))))
        else $error("sync load missed an enabled cell");

    hold_a: assert property ( // R21
        !wr_en |=> ((cell_reg_out & ~$past(upd_vec)) ==
                    ($past(cell_reg_out) & ~$past(upd_vec))))
        else $error("disabled cell register changed");

    aclr_a: assert property ( // R12
        (!greset_reg && g_aclr && !wr_en)
        |=> ((cell_reg_out & ~pe_vec) == '0))
        else $error("async clear left a plain cell set");

    apre_a: assert property ( // R13
        (!greset_reg && g_apre && !wr_en)
        |=> ((cell_reg_out & pe_vec) == pe_vec))
        else $error("async preset left a preset cell low");

    pack_a: assert property ( // R1
        (cfg_reg[0].mode == MODE_NORMAL && cfg_reg[0].pack_en &&
         !cfg_reg[0].use_carry && !cfg_reg[0].preset_emu &&
         live_vec[0] && !greset_reg && !g_sclr && !g_sload && !wr_en)
        |=> (cell_reg_out[0] == $past(cell_data[0][3])))
        else $error("packed register did not take input four");

endmodule : cell_group

// [logic/cell_group_defines.svh]
// register offsets, field positions, reset values and counts of the cell group
`ifndef CELL_GROUP_DEFINES_SVH
`define CELL_GROUP_DEFINES_SVH

// apb byte offsets, one aligned word each
`define OFS_CTRL 8'h00
`define OFS_CELL_SEL 8'h04
`define OFS_CELL_CFG 8'h08
`define OFS_LOAD_DATA 8'h0c
`define OFS_STATUS 8'h10

// group control word fields
`define CTRL_CE0 0
`define CTRL_CE1 1
`define CTRL_SCLR 2
`define CTRL_SLOAD 3
`define CTRL_ACLR 4
`define CTRL_APRE 5
`define CTRL_GINT_LSB 8
`define CTRL_GSRC_LSB 12
`define CTRL_W 16
`define CTRL_RST 16'h0003

// status word fields
`define STAT_KNOWN_LSB 8
`define STAT_GRESET 16
`define STAT_GLINE_LSB 20
`define STAT_USED_LSB 24

// sizing figures of the cell group
`define NUM_CLOCK_ENABLES 2
`define NUM_GLOBAL_LINES 4
`define EXTRA_CELLS_PER_EMU 8'h03

`endif

// [logic/cell_group_pkg.sv]
// types shared by the cell group logic
package cell_group_pkg;

    // operating mode of one logic cell; 2'b11 is not a legal code
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_ARITH = 2'b01,
        MODE_COUNTER = 2'b10
    } cell_mode_t;

    // per-cell configuration word, laid out as the cell config register
    typedef struct packed {
        logic dual_emu;       // [23] simultaneous preset+clear emulation
        logic preset_emu;     // [22] inverted-storage preset emulation
        logic feedback;       // [21] register output feeds lut input one
        logic pack_en;        // [20] register takes input four directly
        logic use_carry;      // [19] carry input feeds the lut
        logic ce_sel;         // [18] which group clock enable is used
        cell_mode_t mode;     // [17:16]
        logic [15:0] lut_mask; // [15:0]
    } cell_cfg_t;

endpackage : cell_group_pkg

// [test/cell_group_bench.sv]
// self-checking bench for the cell group: apb register access and cell flops
`timescale 1ns/1ps
`include "cell_group_defines.svh"

module cell_group_bench;
    import cell_group_pkg::*;

    logic ref_clk = 1'b0; // 125 mhz system clock
    logic rst = 1'b1; // synchronous reset, held at start
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic global_register_reset_n = 1'b1; // chip reset pin, idle high
    logic [3:0] global_pin = 4'h0; // global line pins, idle low
    logic [7:0][3:0] cell_data = '0; // lut inputs of all eight cells
    logic carry_in = 1'b0;
    logic cascade_in = 1'b1; // open cascade so lut results pass
    logic [7:0] cell_comb_out;
    logic [7:0] cell_reg_out;
    logic carry_out; // carry leaving the last cell
    logic cascade_out; // cascade leaving the last cell
    int fail_count = 0; // mismatches seen
    int checked = 0; // comparisons made
    logic [31:0] rd; // last read data
    logic er; // last error response

    cell_group #(.CELLS(8), .RESET_PIN_EN(1'b1)) dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .global_register_reset_n(global_register_reset_n),
        .global_pin(global_pin), .cell_data(cell_data), .carry_in(carry_in),
        .cascade_in(cascade_in), .cell_comb_out(cell_comb_out),
        .cell_reg_out(cell_reg_out), .carry_out(carry_out),
        .cascade_out(cascade_out)
    );

    // free-running clock, 8 ns period
    always #4 ref_clk = ~ref_clk;

    // verdict: one place ends the run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // compare one value; case inequality so unknowns never match
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; entered right after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // the request stands until pready is seen high at an edge
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata; // pre-edge values, flops update later in the step
        er = pslverr;
        if (pready !== 1'b1) begin
            fail_count++;
            $display("ERROR pready expected 1 seen timeout");
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge keeps back-to-back calls from double driving
        @(posedge ref_clk);
    endtask : apb

    // look at the cell flops mid-cycle, where they have settled
    task automatic look(input logic [7:0] mask, input logic [7:0] exp);
        @(negedge ref_clk);
        chk("cell_reg_out", {24'h0, exp & mask}, {24'h0, cell_reg_out & mask});
        @(posedge ref_clk);
    endtask : look

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // reset values: both clock enables on, eight cells in use
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl", 32'h0000_0003, rd);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status used", 32'h8, {24'h0, rd[31:24]});
        // an unmapped word answers with an error and no data
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b0, `OFS_LOAD_DATA, 32'h0);
        chk("mapped err", 32'h0, {31'h0, er});
        // group load reaches every register
        apb(1'b1, `OFS_LOAD_DATA, 32'h0000_00a5);
        apb(1'b1, `OFS_CTRL, 32'h0000_000b);
        look(8'hff, 8'ha5);
        // clear and load together: clear wins
        apb(1'b1, `OFS_CTRL, 32'h0000_000f);
        look(8'hff, 8'h00);
        apb(1'b1, `OFS_CTRL, 32'h0000_000b);
        look(8'hff, 8'ha5);
        // enable zero off: registers on it hold despite the load
        apb(1'b1, `OFS_CTRL, 32'h0000_000a);
        apb(1'b1, `OFS_LOAD_DATA, 32'h0000_005a);
        look(8'hff, 8'ha5);
        // cell 0 moved to enable one picks up the new load bit
        apb(1'b1, `OFS_CELL_SEL, 32'h0);
        apb(1'b1, `OFS_CELL_CFG, 32'h0004_0000);
        look(8'hff, 8'ha4);
        // async clear acts with both enables off
        apb(1'b1, `OFS_CTRL, 32'h0000_0010);
        look(8'hff, 8'h00);
        // arithmetic cell 0: data lut passes input one, both forms out
        cell_data[0] <= 4'h1;
        apb(1'b1, `OFS_CTRL, 32'h0000_0003);
        apb(1'b1, `OFS_CELL_CFG, 32'h0001_00aa);
        @(negedge ref_clk);
        chk("comb out", 32'h1, {24'h0, cell_comb_out});
        @(posedge ref_clk);
        look(8'hff, 8'h01);
        // cell 2 preset-emulated, cell 3 dual-emulated
        apb(1'b1, `OFS_CELL_SEL, 32'h2);
        apb(1'b1, `OFS_CELL_CFG, 32'h0040_0000);
        apb(1'b1, `OFS_CELL_SEL, 32'h3);
        apb(1'b1, `OFS_CELL_CFG, 32'h0080_0000);
        apb(1'b1, `OFS_LOAD_DATA, 32'h0000_00fb);
        apb(1'b1, `OFS_CTRL, 32'h0000_000b);
        look(8'hf7, 8'hfb);
        // chip reset beats the running load; preset cell reads one
        global_register_reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        look(8'hf7, 8'h04);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status greset", 32'h1, {31'h0, rd[16]});
        chk("status used", 32'hb, {24'h0, rd[31:24]});
        chk("status known", 32'h0, {31'h0, rd[11]});
        global_register_reset_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        look(8'hf7, 8'hfb);
        // line 0 from logic, line 2 from its pin: both show in status, line 0 clears the cells
        global_pin <= 4'h4;
        apb(1'b1, `OFS_CTRL, 32'h0000_1103);
        repeat (4) @(posedge ref_clk);
        look(8'hf3, 8'h00);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status lines", 32'h5, {28'h0, rd[23:20]});
        // lines back to idle pins; packed cell 0: flop takes input four
        global_pin <= 4'h0;
        cell_data[0] <= 4'h8;
        apb(1'b1, `OFS_CTRL, 32'h0000_0003);
        apb(1'b1, `OFS_CELL_SEL, 32'h0);
        apb(1'b1, `OFS_CELL_CFG, 32'h0010_00ff);
        @(negedge ref_clk);
        chk("packed comb", 32'h0, {31'h0, cell_comb_out[0]});
        @(posedge ref_clk);
        look(8'h01, 8'h01);
        // carry input in use: packing off, the flop follows the lut
        apb(1'b1, `OFS_CELL_CFG, 32'h0018_00ff);
        look(8'h01, 8'h00);
        // enables off; feedback reaches input one of cell 0, not cell 1
        cell_data[1:0] <= 8'h19;
        apb(1'b1, `OFS_CTRL, 32'h0000_0000);
        apb(1'b1, `OFS_CELL_CFG, 32'h0020_5555);
        apb(1'b1, `OFS_CELL_SEL, 32'h1);
        apb(1'b1, `OFS_CELL_CFG, 32'h0020_5555);
        @(negedge ref_clk);
        chk("feedback comb", 32'h1, {30'h0, cell_comb_out[1:0]});
        @(posedge ref_clk);
        // all cells counter mode: data table is not cin, carry table is cin
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `OFS_CELL_SEL, 32'(i));
            apb(1'b1, `OFS_CELL_CFG, 32'h0002_f00f);
        end
        @(negedge ref_clk);
        chk("counter comb", 32'hff, {24'h0, cell_comb_out});
        chk("carry_out", 32'h0, {31'h0, carry_out});
        chk("cascade_out", 32'h1, {31'h0, cascade_out});
        @(posedge ref_clk);
        carry_in <= 1'b1;
        @(negedge ref_clk);
        chk("counter comb", 32'h0, {24'h0, cell_comb_out});
        chk("carry_out", 32'h1, {31'h0, carry_out});
        chk("cascade_out", 32'h0, {31'h0, cascade_out});
        @(posedge ref_clk);
        // sync clear and load beat whatever the cascade chain offers
        carry_in <= 1'b0;
        apb(1'b1, `OFS_LOAD_DATA, 32'h0000_00ff);
        apb(1'b1, `OFS_CTRL, 32'h0000_0007);
        look(8'hff, 8'h00);
        cascade_in <= 1'b0;
        apb(1'b1, `OFS_CTRL, 32'h0000_000b);
        look(8'hff, 8'hff);
        summarize();
    end
endmodule : cell_group_bench
